// ### hw/aice_top.v
// Purpose: Channel enable registers and clock sufficiency gate
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes: Enable writes queue and are checked in arrival order
//
// The AHB-Lite register port was decided locally.
`timescale 1ns/1ps
`include "aice_defines.vh"

// Function
// - Three ports, eight rx, eight tx channels
// - Tx enable byte, bit n channel n+1
// - Rx enable byte at next address
// - Check clock capacity on enable, refuse
// - Refusal keeps running paths except those the write clears
// - Rate and config writes accepted while enabled
// - Rate code at or above 1000 selects async
module aice_top (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg hreadyout_o,
    output reg hresp_o,
    output reg [31:0] hrdata_o,
    output wire [7:0] port1_tx_channel_on_o,
    output wire [7:0] port1_rx_channel_on_o,
    output wire [7:0] port2_tx_channel_on_o,
    output wire [7:0] port2_rx_channel_on_o,
    output wire [7:0] port3_tx_channel_on_o,
    output wire [7:0] port3_rx_channel_on_o
);
    localparam ST_IDLE = 2'b01;
    localparam ST_CHECK = 2'b10;

    // Enable bytes: 0/1 port1 tx/rx, 2/3 port2, 4/5 port3
    reg [7:0] en_r [0:5];
    reg [`AICE_CLK_W-1:0] sys_cls_r;
    reg [`AICE_CLK_W-1:0] asy_cls_r;
    reg [`AICE_RATE_W-1:0] rate_r [0:2];
    reg refused_r;
    reg [7:0] refused_mask_r;
    reg [1:0] state_r;
    reg [2:0] job_sel_r;
    reg [7:0] job_data_r;

    reg act_r;
    reg wr_r;
    reg [13:0] idx_r;

    wire q_in_ready;
    wire q_out_valid;
    wire [`AICE_Q_WIDTH-1:0] q_out_data;
    wire q_empty;
    wire q_out_ready;
    wire [3:0] sel_w;
    wire [2:0] ph_sel;
    wire ph_is_en;
    wire q_push;
    wire idle_all;
    wire done;

    reg [7:0] cand [0:5];
    reg [7:0] newly;
    reg [5:0] sys_cnt;
    reg [5:0] asy_cnt;
    reg [5:0] sys_cap;
    reg [5:0] asy_cap;
    reg accept;
    reg refuse_set;
    reg [31:0] rd_val;
    integer i;
    integer j;

    function [3:0] pop8;
        input [7:0] v;
        integer k;
        begin
            pop8 = 4'h0;
            for (k = 0; k < 8; k = k + 1) begin
                pop8 = pop8 + {3'b000, v[k]};
            end
        end
    endfunction

    // Maps an index to its enable byte; bit 3 flags no match
    function [3:0] en_sel;
        input [13:0] idx;
        begin
            case (idx)
                `AICE_IDX_P1_TX: en_sel = 4'h0;
                `AICE_IDX_P1_RX: en_sel = 4'h1;
                `AICE_IDX_P2_TX: en_sel = 4'h2;
                `AICE_IDX_P2_RX: en_sel = 4'h3;
                `AICE_IDX_P3_TX: en_sel = 4'h4;
                `AICE_IDX_P3_RX: en_sel = 4'h5;
                default: en_sel = 4'h8;
            endcase
        end
    endfunction

    assign port1_tx_channel_on_o = en_r[0];
    assign port1_rx_channel_on_o = en_r[1];
    assign port2_tx_channel_on_o = en_r[2];
    assign port2_rx_channel_on_o = en_r[3];
    assign port3_tx_channel_on_o = en_r[4];
    assign port3_rx_channel_on_o = en_r[5];

    assign sel_w = en_sel(idx_r);
    assign ph_sel = sel_w[2:0];
    assign ph_is_en = !sel_w[3];
    assign q_push = act_r && wr_r && ph_is_en;
    assign idle_all = q_empty && (state_r == ST_IDLE);
    // Reads wait for queued enable writes so they see settled state;
    // status reads do not, so the busy bit can be seen
    assign done = act_r && (wr_r ? (!ph_is_en || q_in_ready) :
        (idle_all || idx_r == `AICE_IDX_STATUS));
    assign q_out_ready = (state_r == ST_IDLE);

    aice_fifo #(
        .WIDTH(`AICE_Q_WIDTH),
        .DEPTH(`AICE_Q_DEPTH),
        .AW(4)
    ) u_queue (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(q_push),
        .in_ready_o(q_in_ready),
        .in_data_i({ph_sel, hwdata_i[7:0]}),
        .out_valid_o(q_out_valid),
        .out_ready_i(q_out_ready),
        .out_data_o(q_out_data),
        .empty_o(q_empty)
    );

    // Capacity check over the candidate enable set
    always @* begin
        for (i = 0; i < 6; i = i + 1) begin
            cand[i] = en_r[i];
        end
        cand[job_sel_r] = job_data_r;
        newly = job_data_r & ~en_r[job_sel_r];
        sys_cnt = 6'h00;
        asy_cnt = 6'h00;
        for (i = 0; i < 6; i = i + 1) begin
            if (rate_r[i/2] >= `AICE_RATE_ASYNC) begin
                asy_cnt = asy_cnt + {2'b00, pop8(cand[i])};
            end else begin
                sys_cnt = sys_cnt + {2'b00, pop8(cand[i])};
            end
        end
        sys_cap = {3'b000, sys_cls_r} * `AICE_CH_PER_CLASS;
        asy_cap = {3'b000, asy_cls_r} * `AICE_CH_PER_CLASS;
        // Clearing bits is never refused; class 0 means clock off
        accept = (newly == 8'h00) ||
            ((sys_cnt <= sys_cap) && (asy_cnt <= asy_cap));
        refuse_set = (state_r == ST_CHECK) && !accept;
    end

    always @* begin
        rd_val = 32'h0000_0000;
        if (ph_is_en) begin
            rd_val[7:0] = en_r[ph_sel];
        end else if (idx_r == `AICE_IDX_CLKCFG) begin
            rd_val[`AICE_CLK_SYS_LSB +: `AICE_CLK_W] = sys_cls_r;
            rd_val[`AICE_CLK_ASY_LSB +: `AICE_CLK_W] = asy_cls_r;
        end else if (idx_r == `AICE_IDX_RATE) begin
            rd_val[11:0] = {rate_r[2], rate_r[1], rate_r[0]};
        end else if (idx_r == `AICE_IDX_STATUS) begin
            rd_val[`AICE_ST_REFUSED] = refused_r;
            rd_val[`AICE_ST_PENDING] = !idle_all;
            rd_val[`AICE_ST_MASK_LSB +: 8] = refused_mask_r;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            hrdata_o <= 32'h0000_0000;
            act_r <= 1'b0;
            wr_r <= 1'b0;
            idx_r <= 14'h0000;
        end else begin
            if (hreadyout_o && hsel_i && hready_i && htrans_i[1]) begin
                act_r <= 1'b1;
                wr_r <= hwrite_i;
                idx_r <= haddr_i[15:2];
                hreadyout_o <= 1'b0;
            end else if (done) begin
                act_r <= 1'b0;
                hreadyout_o <= 1'b1;
                if (!wr_r) begin
                    hrdata_o <= rd_val;
                end
            end
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            for (j = 0; j < 6; j = j + 1) begin
                en_r[j] <= `AICE_EN_RST;
            end
            for (j = 0; j < 3; j = j + 1) begin
                rate_r[j] <= `AICE_RATE_RST;
            end
            sys_cls_r <= `AICE_CLK_RST;
            asy_cls_r <= `AICE_CLK_RST;
            refused_r <= 1'b0;
            refused_mask_r <= 8'h00;
            state_r <= ST_IDLE;
            job_sel_r <= 3'h0;
            job_data_r <= 8'h00;
        end else begin
            // Config writes go straight through, even with paths on
            if (done && wr_r) begin
                if (idx_r == `AICE_IDX_CLKCFG) begin
                    sys_cls_r <= hwdata_i[`AICE_CLK_SYS_LSB +: `AICE_CLK_W];
                    asy_cls_r <= hwdata_i[`AICE_CLK_ASY_LSB +: `AICE_CLK_W];
                end
                if (idx_r == `AICE_IDX_RATE) begin
                    rate_r[0] <= hwdata_i[3:0];
                    rate_r[1] <= hwdata_i[7:4];
                    rate_r[2] <= hwdata_i[11:8];
                end
            end
            // Sticky refusal flag: a new refusal beats a W1C clear
            if (refuse_set) begin
                refused_r <= 1'b1;
                refused_mask_r <= newly;
            end else if (done && wr_r && idx_r == `AICE_IDX_STATUS &&
                         hwdata_i[`AICE_ST_REFUSED]) begin
                refused_r <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    if (q_out_valid) begin
                        job_sel_r <= q_out_data[10:8];
                        job_data_r <= q_out_data[7:0];
                        state_r <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (accept) begin
                        en_r[job_sel_r] <= job_data_r;
                    end else begin
                        // Keep running bits, honour clears, drop new ones
                        en_r[job_sel_r] <= job_data_r &
                            en_r[job_sel_r];
                    end
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // aice_top

// ### common/aice_defines.vh
// Purpose: Shared constants for the audio port channel enable block
// Assumes: Register index times four gives the AHB byte address
// Notes: Indexes are word indexes on the bus
`ifndef AICE_DEFINES_VH
`define AICE_DEFINES_VH

// Register indexes (byte address = index * 4)
`define AICE_IDX_P1_TX 14'h0519
`define AICE_IDX_P1_RX 14'h051A
`define AICE_IDX_P2_TX 14'h0559
`define AICE_IDX_P2_RX 14'h055A
`define AICE_IDX_P3_TX 14'h0599
`define AICE_IDX_P3_RX 14'h059A
`define AICE_IDX_CLKCFG 14'h0600
`define AICE_IDX_RATE 14'h0601
`define AICE_IDX_STATUS 14'h0602

// Clock configuration fields
`define AICE_CLK_SYS_LSB 0
`define AICE_CLK_ASY_LSB 4
`define AICE_CLK_W 3

// Rate code field width and domain threshold
`define AICE_RATE_W 4
`define AICE_RATE_ASYNC 4'h8

// Status fields
`define AICE_ST_REFUSED 0
`define AICE_ST_PENDING 1
`define AICE_ST_MASK_LSB 8

// Channels served per step of clock class
`define AICE_CH_PER_CLASS 6'h08

// Reset values
`define AICE_EN_RST 8'h00
`define AICE_CLK_RST 3'h0
`define AICE_RATE_RST 4'h0

// Write queue geometry
`define AICE_Q_WIDTH 11
`define AICE_Q_DEPTH 16

`endif

// ### hw/aice_fifo.v
// Purpose: Queue with valid and ready on both sides
// Assumes: One clock, synchronous active-low reset
// Notes: Read data leave from an output register stage
`timescale 1ns/1ps
module aice_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output reg out_valid_o,
    input wire out_ready_i,
    output reg [WIDTH-1:0] out_data_o,
    output wire empty_o
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready_o = (count_r < DEPTH);
    assign push = in_valid_i && in_ready_o;
    assign pop = (count_r != 0) && (!out_valid_o || out_ready_i);
    assign empty_o = (count_r == 0) && !out_valid_o;

    always @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            out_valid_o <= 1'b0;
            out_data_o <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
                out_data_o <= mem_r[rd_ptr_r];
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule // aice_fifo

// ### verif/aice_monitor.sv
// Purpose: Bus and enable output checks for aice_top
// Assumes: One AHB-Lite slave, hready tied back to hreadyout
// Notes: Sees only the top module's ports
`timescale 1ns/1ps
module aice_monitor (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire hsel_i,
    input wire [1:0] htrans_i,
    input wire hready_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [31:0] hrdata_o,
    input wire [7:0] port1_tx_channel_on_o,
    input wire [7:0] port1_rx_channel_on_o,
    input wire [7:0] port2_tx_channel_on_o,
    input wire [7:0] port2_rx_channel_on_o,
    input wire [7:0] port3_tx_channel_on_o,
    input wire [7:0] port3_rx_channel_on_o
);
    wire take = hsel_i && htrans_i[1] && hready_i && hreadyout_o;
    wire [47:0] en = {port3_rx_channel_on_o, port3_tx_channel_on_o,
        port2_rx_channel_on_o, port2_tx_channel_on_o,
        port1_rx_channel_on_o, port1_tx_channel_on_o};
    // Cycles since the last accepted bus request, saturating
    reg [5:0] since_r;
    always @(posedge sys_clk_i) begin
        if (!rst_n_i || take)
            since_r <= 6'h00;
        else if (since_r != 6'h3F)
            since_r <= since_r + 6'h01;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    resp_okay_a: assert property (!hresp_o)
        else $error("error response seen");
    reset_values_a: assert property (disable iff (1'b0)
        !rst_n_i |=> hreadyout_o && en == 48'h0000_0000_0000)
        else $error("outputs not at reset values");
    take_waits_a: assert property (take |=> !hreadyout_o)
        else $error("no wait state after request");
    wait_bound_a: assert property (
        $fell(hreadyout_o) |-> ##[1:60] hreadyout_o)
        else $error("wait state too long");
    idle_ready_a: assert property (
        hreadyout_o && !(hsel_i && htrans_i[1]) |=> hreadyout_o)
        else $error("wait state without request");
    rdata_hold_a: assert property (
        hreadyout_o && !take |=> $stable(hrdata_o))
        else $error("read data changed while idle");
    rdata_upper_a: assert property (hrdata_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    en_cause_a: assert property (!$stable(en) |-> since_r < 6'h3F)
        else $error("enable changed without a write");
endmodule // aice_monitor
bind aice_top aice_monitor u_mon (.sys_clk_i, .rst_n_i, .hsel_i,
    .htrans_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o,
    .port1_tx_channel_on_o, .port1_rx_channel_on_o,
    .port2_tx_channel_on_o, .port2_rx_channel_on_o,
    .port3_tx_channel_on_o, .port3_rx_channel_on_o);

// ### verif/aice_audio_dev.sv
// Purpose: Far-side audio device watching one port's enables
// Assumes: Enable bytes are levels, high = channel on
// Notes: Reports how many channels carry samples
`timescale 1ns/1ps
module aice_audio_dev (
    input wire [7:0] tx_on_i,
    input wire [7:0] rx_on_i,
    output reg [4:0] live_o
);
    integer k;
    always @* begin
        live_o = 5'h00;
        for (k = 0; k < 8; k = k + 1) begin
            live_o = live_o + {4'h0, tx_on_i[k]} + {4'h0, rx_on_i[k]};
        end
    end
endmodule // aice_audio_dev

// ### verif/audio_if_channel_enable_tb_top.sv
// Purpose: Self-checking bench for aice_top
// Assumes: hready tied to hreadyout, one slave
// Notes: Enable outputs settle 4 edges after a write
`timescale 1ns/1ps
`include "aice_defines.vh"
module audio_if_channel_enable_tb_top;
    typedef struct packed {
        logic [13:0] idx;
        logic [31:0] wd;
        logic [31:0] ex;
    } aice_row_t;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [1:0] htrans = 2'h0;
    reg [31:0] haddr = 32'h0000_0000;
    reg [31:0] hwdata = 32'h0000_0000;
    reg hwrite = 1'b0;
    reg [31:0] rd;
    wire hready;
    wire hresp;
    wire [31:0] hrdata;
    wire [7:0] en [0:5];
    wire [4:0] live;
    integer n_fail = 0;
    integer samples_checked = 0;
    integer k;
    aice_row_t rows [0:7] = '{
        '{`AICE_IDX_P1_TX, 32'h0000_1281, 32'h0000_0081},
        '{`AICE_IDX_P1_RX, 32'h0000_0042, 32'h0000_0042},
        '{`AICE_IDX_P2_TX, 32'h0000_0024, 32'h0000_0024},
        '{`AICE_IDX_P2_RX, 32'h0000_0018, 32'h0000_0018},
        '{`AICE_IDX_P3_TX, 32'h0000_00FF, 32'h0000_00FF},
        '{`AICE_IDX_P3_RX, 32'h0000_0001, 32'h0000_0001},
        '{`AICE_IDX_RATE, 32'h0000_0321, 32'h0000_0321},
        '{14'h0700, 32'h0000_FFFF, 32'h0000_0000}};
    aice_top dut (.sys_clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .port1_tx_channel_on_o(en[0]), .port1_rx_channel_on_o(en[1]),
        .port2_tx_channel_on_o(en[2]), .port2_rx_channel_on_o(en[3]),
        .port3_tx_channel_on_o(en[4]), .port3_rx_channel_on_o(en[5]));
    aice_audio_dev u_dev (.tx_on_i(en[0]), .rx_on_i(en[1]),
        .live_o(live));
    initial begin
        forever #2 clk = ~clk;
    end
    task finish_test;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_fail = n_fail + 1;
        finish_test;
    end
    task check(input [31:0] seen, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t seen %h expected %h",
                $time, seen, exp);
        end
    endtask
    // Address phase held until taken, data phase until hready high
    task bus(input w, input [13:0] i, input [31:0] d);
        htrans <= 2'h2;
        haddr <= {16'h0000, i, 2'h0};
        hwrite <= w;
        do @(negedge clk); while (hready !== 1'b1);
        @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        do @(negedge clk); while (hready !== 1'b1);
        rd = hrdata;
        @(posedge clk);
    endtask
    task wr(input [13:0] i, input [31:0] d);
        bus(1'b1, i, d);
    endtask
    task rdchk(input [13:0] i, input [31:0] e);
        bus(1'b0, i, 32'h0000_0000);
        check(rd, e);
    endtask
    task settle(input integer p, input [7:0] e);
        repeat (4) @(posedge clk);
        #1;
        check({24'h00_0000, en[p]}, {24'h00_0000, e});
        @(posedge clk);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wr(`AICE_IDX_CLKCFG, 32'h0000_0077);
        for (k = 0; k < 8; k = k + 1) begin
            wr(rows[k].idx, rows[k].wd);
            if (k < 6) settle(k, rows[k].ex[7:0]);
            rdchk(rows[k].idx, rows[k].ex);
        end
        check({27'h000_0000, live}, 32'h0000_0004);
        $display("rows done");
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (k = 0; k < 6; k = k + 1) begin
            check({24'h00_0000, en[k]}, 32'h0000_0000);
            rdchk(rows[k].idx, 32'h0000_0000);
        end
        $display("reset done");
        wr(`AICE_IDX_CLKCFG, 32'h0000_0001);
        wr(`AICE_IDX_P1_TX, 32'h0000_00FF);
        settle(0, 8'hFF);
        wr(`AICE_IDX_P1_RX, 32'h0000_0001);
        settle(1, 8'h00);
        settle(0, 8'hFF);
        rdchk(`AICE_IDX_STATUS, 32'h0000_0101);
        wr(`AICE_IDX_STATUS, 32'h0000_0001);
        rdchk(`AICE_IDX_STATUS, 32'h0000_0100);
        wr(`AICE_IDX_P1_TX, 32'h0000_007F);
        wr(`AICE_IDX_P1_RX, 32'h0000_0001);
        settle(1, 8'h01);
        settle(0, 8'h7F);
        $display("refusal done");
        wr(`AICE_IDX_P1_TX, 32'h0000_0000);
        wr(`AICE_IDX_P1_RX, 32'h0000_0000);
        wr(`AICE_IDX_CLKCFG, 32'h0000_0010);
        wr(`AICE_IDX_RATE, 32'h0000_0080);
        wr(`AICE_IDX_P2_TX, 32'h0000_00FF);
        settle(2, 8'hFF);
        wr(`AICE_IDX_RATE, 32'h0000_0070);
        rdchk(`AICE_IDX_RATE, 32'h0000_0070);
        wr(`AICE_IDX_P2_RX, 32'h0000_0001);
        settle(3, 8'h00);
        settle(2, 8'hFF);
        wr(`AICE_IDX_STATUS, 32'h0000_0001);
        $display("domain done");
        wr(`AICE_IDX_CLKCFG, 32'h0000_0077);
        for (k = 0; k < 20; k = k + 1)
            wr(`AICE_IDX_P3_TX, k);
        rdchk(`AICE_IDX_P3_TX, 32'h0000_0013);
        settle(4, 8'h13);
        rdchk(`AICE_IDX_STATUS, 32'h0000_0100);
        wr(`AICE_IDX_P3_TX, 32'h0000_0000);
        rdchk(`AICE_IDX_STATUS, 32'h0000_0102);
        settle(4, 8'h00);
        $display("queue done");
        finish_test;
    end
endmodule // audio_if_channel_enable_tb_top
